// [ldsw_fsm.sv]
// Purpose: Control state machine of a bidirectional dual input load switch
// Assumes: Analog comparators deliver levels; pins arrive asynchronously
// Notes: Overvoltage gate on the switch is combinational by design
// Notes on behaviour
// - Overvoltage opens switch at once, state untouched
// - Level select grounded picks higher trip
// - Autonomous mode switches on valid input supply
// - No input supply keeps wireless disable low
// - Input detected releases wireless disable high
// - Discharge output before closing switch
// - Input removed powers down, wireless disable low
// - Handshake pin normally driven low
// - Valid output, no input releases handshake pin
// - Handshake pulled low closes switch, wireless high
// - Handshake released reopens switch, wireless low after the discharge period
// - Slave mode follows debounced enable pin
// - Enable high at power-up selects slave mode
// - Slave mode uses same pin scheme
// - Concurrent OTG forces wireless disable low
// - Machine runs only while core powered
// - Power lost when both rails below lockout
// - Enable and disable events debounced
// - Valid input after input debounce period
// - Valid output needs output debounce, no input
// - Output discharged is undebounced below lockout
// - OTG enable and disable debounced on handshake
// - Pin and output debounce about 40 us
// - Input debounce about 50 ms
// - Discharge period about 50 ms
// - Initialisation about 150 us after power
`timescale 1ns/1ps
module ldsw_fsm #(
  parameter int unsigned DEB_IN_CYC = ldsw_pkg::CYC_DEB_IN,
  parameter int unsigned DIS_CYC = ldsw_pkg::CYC_DIS
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic in_uvlo_ok_i,
  input wire logic out_uvlo_ok_i,
  input wire logic ovp_hi_trip_i,
  input wire logic ovp_lo_trip_i,
  input wire logic level_select_pin_i,
  input wire logic en_n_i,
  input wire logic handshake_i,
  input wire logic concurrent_otg_i,
  output logic switch_on_o,
  output logic discharge_o,
  output logic rx_dis_o,
  output logic rx_dis_oe_o,
  output logic handshake_o,
  output logic handshake_oe_o,
  output logic slave_mode_o
);
  localparam int CW = ldsw_pkg::CNT_W;
  localparam logic [CW-1:0] PIN_CYC = CW'(ldsw_pkg::CYC_DEB_PIN);
  localparam logic [CW-1:0] OUTD_CYC = CW'(ldsw_pkg::CYC_DEB_OUT);
  localparam logic [CW-1:0] IN_CYC = CW'(DEB_IN_CYC);
  localparam logic [CW-1:0] DIS_C = CW'(DIS_CYC);
  localparam logic [CW-1:0] INIT_C = CW'(ldsw_pkg::CYC_INIT);
  localparam logic [CW-1:0] ONE_C = CW'(1);

  typedef struct packed {
    ldsw_pkg::ldsw_state_e fsm;
    logic [CW-1:0] tmr;
    logic sw;
    logic dis;
    logic rx_rel;
    logic hs_rel;
    logic slave;
    logic ovp;
  } ldsw_top_s;
  ldsw_top_s st;
  ldsw_top_s next_st;

  logic in_s;
  logic out_s;
  logic en_s;
  logic hs_s;
  logic ovh_s;
  logic ovl_s;
  logic sel_s;
  logic cotg_s;
  logic powered;
  logic valid_in;
  logic out_deb;
  logic en_high;
  logic hs_high;
  logic valid_out;
  logic out_disch;
  logic ovp_now;
  logic hs_clr;
  logic hs_d;
  logic trip_raw;

  ldsw_sync u_sync_in (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .d_i(in_uvlo_ok_i),
    .q_o(in_s));
  ldsw_sync u_sync_out (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .d_i(out_uvlo_ok_i),
    .q_o(out_s));
  ldsw_sync #(.RST_VAL(1'b1)) u_sync_en (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .d_i(en_n_i), .q_o(en_s));
  ldsw_sync u_sync_hs (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .d_i(handshake_i),
    .q_o(hs_s));
  ldsw_sync u_sync_ovh (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .d_i(ovp_hi_trip_i),
    .q_o(ovh_s));
  ldsw_sync u_sync_ovl (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .d_i(ovp_lo_trip_i),
    .q_o(ovl_s));
  ldsw_sync #(.RST_VAL(1'b1)) u_sync_sel (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .d_i(level_select_pin_i), .q_o(sel_s));
  ldsw_sync u_sync_cotg (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .d_i(concurrent_otg_i), .q_o(cotg_s));

  assign powered = in_s | out_s;
  assign out_disch = ~out_s;
  // Grounded select uses the higher trip comparator, floating the lower
  assign ovp_now = sel_s ? ovl_s : ovh_s;

  ldsw_debounce #(.CNT_W(CW), .RISE_CYC(IN_CYC), .FALL_CYC(ONE_C)) u_deb_in (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .clr_i(1'b0), .d_i(in_s),
    .q_o(valid_in));
  ldsw_debounce #(.CNT_W(CW), .RISE_CYC(OUTD_CYC), .FALL_CYC(ONE_C)) u_deb_out (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .clr_i(1'b0), .d_i(out_s),
    .q_o(out_deb));
  assign valid_out = out_deb & ~valid_in;
  ldsw_debounce #(.CNT_W(CW), .RISE_CYC(PIN_CYC), .FALL_CYC(PIN_CYC), .RST_VAL(1'b1))
    u_deb_en (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .clr_i(1'b0), .d_i(en_s),
    .q_o(en_high));

  // Handshake level only counts while the pin is released by us
  assign hs_clr = ~st.hs_rel;
  assign hs_d = hs_s;
  ldsw_debounce #(.CNT_W(CW), .RISE_CYC(PIN_CYC), .FALL_CYC(PIN_CYC), .RST_VAL(1'b1))
    u_deb_hs (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .clr_i(hs_clr), .d_i(hs_d),
    .q_o(hs_high));

  always_comb
  begin
    next_st = st;
    next_st.ovp = ovp_now;
    next_st.tmr = (st.tmr != '0) ? st.tmr - ONE_C : '0;
    if (!powered)
    begin
      next_st.fsm = ldsw_pkg::LDSW_OFF;
    end
    else
    begin
      case (st.fsm)
        ldsw_pkg::LDSW_OFF:
        begin
          next_st.fsm = ldsw_pkg::LDSW_INIT;
          next_st.tmr = INIT_C;
        end
        ldsw_pkg::LDSW_INIT:
        begin
          if (st.tmr == '0)
          begin
            // A high enable at or shortly after power-up latches slave mode
            next_st.slave = en_high;
            next_st.fsm = en_high ? ldsw_pkg::LDSW_SLAVE_READY
                                  : ldsw_pkg::LDSW_AUTO_READY;
          end
        end
        ldsw_pkg::LDSW_AUTO_READY:
        begin
          if (en_high)
            next_st.fsm = ldsw_pkg::LDSW_SLAVE_READY;
          else if (valid_in)
          begin
            next_st.fsm = ldsw_pkg::LDSW_AUTO_DISCH;
            next_st.tmr = DIS_C;
          end
          else if (valid_out)
            next_st.fsm = ldsw_pkg::LDSW_OTG_READY;
        end
        ldsw_pkg::LDSW_AUTO_DISCH:
        begin
          if (en_high)
            next_st.fsm = ldsw_pkg::LDSW_SLAVE_READY;
          else if (!valid_in)
            next_st.fsm = ldsw_pkg::LDSW_AUTO_READY;
          else if (st.tmr == '0 && out_disch)
            next_st.fsm = ldsw_pkg::LDSW_AUTO_ON;
        end
        ldsw_pkg::LDSW_AUTO_ON:
        begin
          if (en_high)
            next_st.fsm = ldsw_pkg::LDSW_SLAVE_READY;
          else if (!valid_in)
            next_st.fsm = ldsw_pkg::LDSW_AUTO_READY;
        end
        ldsw_pkg::LDSW_OTG_READY:
        begin
          if (en_high)
            next_st.fsm = ldsw_pkg::LDSW_OTG_SLV_READY;
          else if (!valid_out)
            next_st.fsm = ldsw_pkg::LDSW_AUTO_READY;
          else if (!hs_high)
            next_st.fsm = ldsw_pkg::LDSW_OTG_ON;
        end
        ldsw_pkg::LDSW_OTG_ON:
        begin
          if (en_high)
            next_st.fsm = ldsw_pkg::LDSW_SLAVE_READY;
          else if (hs_high)
          begin
            next_st.fsm = ldsw_pkg::LDSW_OTG_DISCH;
            next_st.tmr = DIS_C;
          end
        end
        ldsw_pkg::LDSW_OTG_DISCH:
        begin
          if (en_high)
            next_st.fsm = ldsw_pkg::LDSW_SLAVE_READY;
          else if (st.tmr == '0)
            next_st.fsm = ldsw_pkg::LDSW_OTG_READY;
        end
        ldsw_pkg::LDSW_SLAVE_READY:
        begin
          if (!en_high)
          begin
            next_st.fsm = ldsw_pkg::LDSW_SLAVE_DISCH;
            next_st.tmr = DIS_C;
          end
          else if (valid_out)
            next_st.fsm = ldsw_pkg::LDSW_OTG_SLV_READY;
        end
        ldsw_pkg::LDSW_OTG_SLV_READY:
        begin
          if (!en_high)
            next_st.fsm = ldsw_pkg::LDSW_SLAVE_ON;
          else if (!valid_out)
            next_st.fsm = ldsw_pkg::LDSW_SLAVE_READY;
        end
        ldsw_pkg::LDSW_SLAVE_DISCH:
        begin
          if (en_high)
            next_st.fsm = ldsw_pkg::LDSW_SLAVE_READY;
          else if (st.tmr == '0 && out_disch)
            next_st.fsm = ldsw_pkg::LDSW_SLAVE_ON;
        end
        ldsw_pkg::LDSW_SLAVE_ON:
        begin
          if (en_high)
            next_st.fsm = ldsw_pkg::LDSW_SLAVE_READY;
        end
        default:
        begin
          next_st.fsm = ldsw_pkg::LDSW_OFF;
        end
      endcase
    end

    // Outputs decoded from the state being entered, so pins follow in one cycle
    next_st.sw = 1'b0;
    next_st.dis = 1'b0;
    next_st.rx_rel = 1'b0;
    next_st.hs_rel = 1'b0;
    case (next_st.fsm)
      ldsw_pkg::LDSW_AUTO_DISCH, ldsw_pkg::LDSW_OTG_DISCH, ldsw_pkg::LDSW_SLAVE_DISCH:
      begin
        next_st.dis = 1'b1;
        next_st.rx_rel = 1'b1;
        next_st.hs_rel = (next_st.fsm == ldsw_pkg::LDSW_OTG_DISCH);
      end
      ldsw_pkg::LDSW_AUTO_ON, ldsw_pkg::LDSW_SLAVE_ON:
      begin
        next_st.sw = 1'b1;
        next_st.rx_rel = 1'b1;
      end
      ldsw_pkg::LDSW_OTG_ON:
      begin
        next_st.sw = 1'b1;
        next_st.rx_rel = 1'b1;
        next_st.hs_rel = 1'b1;
      end
      ldsw_pkg::LDSW_OTG_READY, ldsw_pkg::LDSW_OTG_SLV_READY:
      begin
        next_st.hs_rel = 1'b1;
      end
      default:
      begin
        next_st.sw = 1'b0;
      end
    endcase
    if (cotg_s)
      next_st.rx_rel = 1'b0;
  end

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st <= '{fsm: ldsw_pkg::LDSW_OFF, tmr: '0, sw: 1'b0, dis: 1'b0, rx_rel: 1'b0,
              hs_rel: 1'b0, slave: 1'b0, ovp: 1'b0};
    end
    else
    begin
      st <= next_st;
    end
  end

  // Overvoltage gate is asynchronous on the raw comparator; the state is not touched
  assign trip_raw = level_select_pin_i ? ovp_lo_trip_i : ovp_hi_trip_i;
  // Re-close waits for the synchronised trip as well, so a chattering comparator
  // cannot pump the switch closed between its crossings
  assign switch_on_o = st.sw & ~trip_raw & ~st.ovp;
  assign discharge_o = st.dis;
  assign rx_dis_o = 1'b0;
  assign rx_dis_oe_o = ~st.rx_rel;
  assign handshake_o = 1'b0;
  assign handshake_oe_o = ~st.hs_rel;
  assign slave_mode_o = st.slave;
endmodule // ldsw_fsm

// [ldsw_pkg.sv]
// Purpose: Shared constants and types of the load switch control logic
// Assumes: Core clock of 10 MHz
// Notes: Times are held in their own units; cycle counts derive from them
package ldsw_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned T_DEB_PIN_US = 40;
  localparam int unsigned T_DEB_OUT_US = 40;
  localparam int unsigned T_DEB_IN_MS = 50;
  localparam int unsigned T_DIS_MS = 50;
  localparam int unsigned T_INIT_US = 150;
  localparam int unsigned CYC_DEB_PIN = T_DEB_PIN_US * (CLK_HZ / 1_000_000);
  localparam int unsigned CYC_DEB_OUT = T_DEB_OUT_US * (CLK_HZ / 1_000_000);
  localparam int unsigned CYC_DEB_IN = T_DEB_IN_MS * (CLK_HZ / 1_000);
  localparam int unsigned CYC_DIS = T_DIS_MS * (CLK_HZ / 1_000);
  localparam int unsigned CYC_INIT = T_INIT_US * (CLK_HZ / 1_000_000);
  localparam int CNT_W = 20;

  typedef enum logic [3:0] {
    LDSW_OFF = 4'h0,
    LDSW_INIT = 4'h1,
    LDSW_AUTO_READY = 4'h2,
    LDSW_AUTO_DISCH = 4'h3,
    LDSW_AUTO_ON = 4'h4,
    LDSW_OTG_READY = 4'h5,
    LDSW_OTG_ON = 4'h6,
    LDSW_OTG_DISCH = 4'h7,
    LDSW_SLAVE_READY = 4'h8,
    LDSW_OTG_SLV_READY = 4'h9,
    LDSW_SLAVE_ON = 4'ha,
    LDSW_SLAVE_DISCH = 4'hb
  } ldsw_state_e;
endpackage

// [ldsw_sync.sv]
// Purpose: Two-flop synchroniser for a pin or comparator level
// Assumes: Reset value is the idle level of the pin
// Notes: The first stage is read only by the second
`timescale 1ns/1ps
module ldsw_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic d_i,
  output logic q_o
);
  typedef struct packed {
    logic meta;
    logic sync;
  } ldsw_sync_s;
  ldsw_sync_s st;
  ldsw_sync_s next_st;

  always_comb
  begin
    next_st.meta = d_i;
    next_st.sync = st.meta;
  end

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st <= {RST_VAL, RST_VAL};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign q_o = st.sync;
endmodule // ldsw_sync

// [ldsw_debounce.sv]
// Purpose: Debounce a synchronised level separately for rise and fall
// Assumes: Input already synchronised to core_clk_i
// Notes: Output changes only after the new level held for its full period, or at once to RST_VAL on clr_i
`timescale 1ns/1ps
module ldsw_debounce #(
  parameter int CNT_W = 20,
  parameter logic [CNT_W-1:0] RISE_CYC = '1,
  parameter logic [CNT_W-1:0] FALL_CYC = '1,
  parameter logic RST_VAL = 1'b0
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic clr_i,
  input wire logic d_i,
  output logic q_o
);
  typedef struct packed {
    logic q;
    logic [CNT_W-1:0] cnt;
  } ldsw_deb_s;
  ldsw_deb_s st;
  ldsw_deb_s next_st;

  always_comb
  begin
    next_st = st;
    if (clr_i)
    begin
      next_st.q = RST_VAL;
      next_st.cnt = '0;
    end
    else if (d_i == st.q)
    begin
      next_st.cnt = '0;
    end
    else if (st.cnt + 1'b1 >= (d_i ? RISE_CYC : FALL_CYC))
    begin
      next_st.q = d_i;
      next_st.cnt = '0;
    end
    else
    begin
      next_st.cnt = st.cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st <= '{q: RST_VAL, cnt: '0};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign q_o = st.q;
endmodule // ldsw_debounce

// [ldsw_chk.sv]
// Purpose: Port checks of the load switch control
// Assumes: Bound to ldsw_fsm; input debounce of at least 41 cycles
// Notes: Look-back depths leave room for the input synchronisers
`timescale 1ns/1ps
module ldsw_chk (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic in_uvlo_ok_i,
  input wire logic out_uvlo_ok_i,
  input wire logic ovp_hi_trip_i,
  input wire logic ovp_lo_trip_i,
  input wire logic level_select_pin_i,
  input wire logic en_n_i,
  input wire logic handshake_i,
  input wire logic concurrent_otg_i,
  input wire logic switch_on_o,
  input wire logic discharge_o,
  input wire logic rx_dis_o,
  input wire logic rx_dis_oe_o,
  input wire logic handshake_o,
  input wire logic handshake_oe_o,
  input wire logic slave_mode_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);
  AST_OVP_HI: assert property (ovp_hi_trip_i && !level_select_pin_i |-> !switch_on_o)
    else $error("switch closed on high trip");
  AST_OVP_LO: assert property (ovp_lo_trip_i && level_select_pin_i |-> !switch_on_o)
    else $error("switch closed on low trip");
  AST_OFF: assert property ((!in_uvlo_ok_i && !out_uvlo_ok_i) [*5]
    |-> !switch_on_o && !discharge_o && rx_dis_oe_o && handshake_oe_o)
    else $error("not off without power");
  AST_BBM: assert property (switch_on_o |-> !discharge_o)
    else $error("switch closed while discharging");
  AST_RX_REL: assert property ((!concurrent_otg_i [*4] ##0 (switch_on_o || discharge_o))
    |-> !rx_dis_oe_o)
    else $error("receiver left enabled");
  AST_CONC: assert property (concurrent_otg_i [*4] |-> rx_dis_oe_o)
    else $error("receiver not forced on");
  AST_OTG_DEB: assert property ($rose(switch_on_o) && !handshake_oe_o
    |-> !$past(handshake_i, 300))
    else $error("otg closed without debounce");
  AST_SLV_DEB: assert property ($rose(switch_on_o) && slave_mode_o
    |-> !$past(en_n_i, 300))
    else $error("slave closed without debounce");
  AST_HS_REL: assert property ($fell(handshake_oe_o) |-> $past(out_uvlo_ok_i, 300))
    else $error("handshake released without output");
  AST_AUTO_DIS: assert property ($rose(discharge_o) && handshake_oe_o && !slave_mode_o
    |-> $past(in_uvlo_ok_i, 40))
    else $error("discharge without valid input");
endmodule // ldsw_chk

// [ldsw_sys_model.sv]
// Purpose: System controller and wireless receiver at the pins
// Assumes: Both pins open drain with on-chip pull-ups
// Notes: A released pin reads high through its pull-up
`timescale 1ns/1ps
module ldsw_sys_model (
  input wire logic sys_en_i,
  input wire logic otg_req_i,
  input wire logic hs_oe_i,
  input wire logic rx_oe_i,
  output logic en_n_o,
  output logic hs_level_o,
  output logic rx_level_o
);
  assign en_n_o = !sys_en_i;
  // Wired low of device and system over the pull-up
  assign hs_level_o = !(hs_oe_i || otg_req_i);
  assign rx_level_o = !rx_oe_i;
endmodule // ldsw_sys_model

// [test_dual_input_load_switch_fsm.sv]
// Purpose: Self-checking bench of the load switch control
// Assumes: Short input debounce and discharge counts of 50
// Notes: Inputs change 10 ns after the rising edge
`timescale 1ns/1ps
module test_dual_input_load_switch_fsm;
  logic core_clk_i = 0, nrst_i = 0, in_uvlo_ok_i = 0, out_uvlo_ok_i = 0;
  logic ovp_hi_trip_i = 0, ovp_lo_trip_i = 0, level_select_pin_i = 1;
  logic concurrent_otg_i = 0, sys_en = 1, otg_req = 0;
  logic en_n_i, handshake_i, rx_level, switch_on_o, discharge_o, rx_dis_o;
  logic rx_dis_oe_o, handshake_o, handshake_oe_o, slave_mode_o;
  int num_errors = 0, comparisons = 0, cycles = 0;
  logic [7:0] lf = 8'h3b;
  always #50 core_clk_i = !core_clk_i;
  ldsw_fsm #(.DEB_IN_CYC(50), .DIS_CYC(50)) dut (.*);
  ldsw_sys_model model (.sys_en_i(sys_en), .otg_req_i(otg_req), .hs_oe_i(handshake_oe_o),
    .rx_oe_i(rx_dis_oe_o), .en_n_o(en_n_i), .hs_level_o(handshake_i), .rx_level_o(rx_level));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // A trip only counts at the level that the select pin picks
  function automatic logic sw_exp(input logic hi, lo, sel, closed);
    return closed && !(sel ? lo : hi);
  endfunction
  task automatic final_report();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge core_clk_i);
    #10;
  endtask
  task automatic chk(input logic got, input logic exp, input string msg);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask
  task automatic wait_for(input int sel, input logic v, input int lim);
    logic s;
    for (int i = 0; i < lim; i++)
    begin
      s = sel == 0 ? switch_on_o : sel == 1 ? discharge_o : handshake_i;
      if (s === v)
        return;
      step(1);
    end
    chk(!v, v, "wait expired");
  endtask
  task automatic power(input logic in, input logic out);
    nrst_i = 0;
    in_uvlo_ok_i = 0;
    out_uvlo_ok_i = 0;
    step(3);
    nrst_i = 1;
    step(2);
    in_uvlo_ok_i = in;
    out_uvlo_ok_i = out;
    step(100);
    chk(rx_level, 0, "rx high in init");
    chk(handshake_i, 0, "handshake high in init");
    chk(switch_on_o, 0, "closed in init");
    chk(rx_dis_o, 0, "rx data not low");
    chk(handshake_o, 0, "handshake data not low");
  endtask
  always @(posedge core_clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      final_report();
    end
  end
  initial
  begin
    power(1, 0);
    wait_for(1, 1, 1600);
    chk(rx_level, 1, "rx not disabled");
    wait_for(0, 1, 100);
    chk(slave_mode_o, 0, "slave in auto");
    for (int i = 0; i < 12; i++)
    begin
      lf = lfsr(lf);
      {ovp_hi_trip_i, ovp_lo_trip_i, level_select_pin_i} = lf[2:0];
      #1;
      chk(switch_on_o, sw_exp(lf[2], lf[1], lf[0], 1), "trip gate");
      step(1);
      ovp_hi_trip_i = 0;
      ovp_lo_trip_i = 0;
      step(4);
      chk(switch_on_o, 1, "no reclose after trip");
    end
    ovp_hi_trip_i = 0;
    ovp_lo_trip_i = 0;
    step(5);
    chk(switch_on_o, 1, "state lost on trip");
    concurrent_otg_i = 1;
    step(5);
    chk(rx_level, 0, "rx not forced low");
    concurrent_otg_i = 0;
    in_uvlo_ok_i = 0;
    step(5);
    chk(switch_on_o, 0, "closed after removal");
    chk(rx_level, 0, "rx not reenabled");
    power(0, 1);
    wait_for(2, 1, 1900);
    otg_req = 1;
    step(300);
    otg_req = 0;
    step(5);
    otg_req = 1;
    step(300);
    chk(switch_on_o, 0, "glitch not restarted");
    wait_for(0, 1, 200);
    chk(rx_level, 1, "rx low in otg");
    otg_req = 0;
    wait_for(1, 1, 500);
    chk(switch_on_o, 0, "closed after release");
    step(45);
    chk(discharge_o, 1, "discharge short");
    wait_for(1, 0, 20);
    chk(rx_level, 0, "rx high after otg");
    sys_en = 0;
    step(410);
    chk(handshake_i, 1, "handshake low after slave exit");
    chk(switch_on_o, 0, "closed after slave exit");
    power(1, 0);
    step(1500);
    chk(slave_mode_o, 1, "slave not chosen");
    chk(switch_on_o, 0, "slave closed unasked");
    sys_en = 1;
    wait_for(0, 1, 600);
    chk(rx_level, 1, "rx low in slave");
    sys_en = 0;
    step(300);
    chk(switch_on_o, 1, "early disable");
    wait_for(0, 0, 200);
    final_report();
  end
endmodule // test_dual_input_load_switch_fsm
bind ldsw_fsm ldsw_chk chk (.*);
